// ==== shared/pps_pkg.sv ====
// Constants, modes and pin carriers for the preset pulse serial shifter.
// Assumes a single 20 MHz reference clock; every pin input is synchronised in the block.
package pps_pkg;

  // Widths fixed at the documented sizes
  localparam int STAGES       = 4;   // Shift register stages
  localparam int PATTERN_BITS = 16;  // Pattern emitter depth
  localparam int CNT_W        = 5;   // Pulse counters, holds up to 31
  localparam int DLY_W        = 8;   // Half period delay count
  localparam int SYNC_W       = 5;   // Number of synchronised pin inputs

  // Clock and timing
  localparam int CLK_PERIOD_NS   = 50;    // 20 MHz reference clock
  localparam int IDLE_LOW_NS     = 2000;  // Low time on the line that arms a burst
  // Least time: round up to whole cycles
  localparam int IDLE_LOW_CYCLES = (IDLE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] IDLE_LOW_LAST = 8'(IDLE_LOW_CYCLES - 1);

  // Reset values
  localparam logic [DLY_W-1:0]        DLY_RST     = 8'h00;
  localparam logic [CNT_W-1:0]        CNT_RST     = 5'h00;
  localparam logic [CNT_W-1:0]        STAGE_COUNT = 5'h04;  // Burst length in internal rx
  localparam logic [STAGES-1:0]       STAGE_RST   = 4'h0;
  localparam logic [PATTERN_BITS-1:0] PATTERN_RST = 16'h0000;
  localparam logic [SYNC_W-1:0]       SYNC_RST    = 5'h02;  // Clear input idles high

  // Synchroniser bit positions
  localparam int SY_START = 0;
  localparam int SY_CLR_N = 1;
  localparam int SY_EXTCK = 2;
  localparam int SY_DATA  = 3;
  localparam int SY_PINCK = 4;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_EXT_RX   = 2'b00,  // Shift on the external clock
    MODE_INT_RX   = 2'b01,  // Shift on an internal burst armed by a low line
    MODE_TX_FIRST = 2'b10,  // Transmit a pattern, then receive on partner clock
    MODE_IDLE     = 2'b11   // Burst only, no shifting
  } mode_e;

  // One two-way pin as seen from the block
  typedef struct packed {
    logic out;  // Level driven onto the pin
    logic oe;   // High while the block drives the pin
  } pin_drive_s;

endpackage : pps_pkg

// ==== hw/preset_pulse_serial_shifter.sv ====
// Preset pulse burst generator with a four stage shift register and a
// transmit-first bidirectional pin pair.
// Assumes one reference clock; start, clear, external clock, data and clock
// pins come from outside and are synchronised here. Configuration inputs are
// static or from logic on the reference clock.
`timescale 1ns/1ps

module preset_pulse_serial_shifter
  import pps_pkg::*;
(
  input  wire logic                    i_ref_clk,     // 20 MHz reference clock
  input  wire logic                    i_rst_n,       // Asynchronous reset, active low
  input  wire mode_e                   i_mode,        // Operating mode
  input  wire logic [DLY_W-1:0]        i_half_period, // Delay cycles per oscillator edge
  input  wire logic [CNT_W-1:0]        i_burst_count, // Pulses per burst, plain modes
  input  wire logic [CNT_W-1:0]        i_tx_count,    // Pulses per transmission
  input  wire logic                    i_start,       // Start pin
  input  wire logic                    i_clear_n,     // Shift register clear pin, active low
  input  wire logic                    i_ext_clk,     // External shift clock pin
  input  wire logic                    i_data_pin,    // Data pin input level
  input  wire logic                    i_clk_pin,     // Clock pin input level
  input  wire logic                    i_load_sel,    // Parallel load select
  input  wire logic                    i_load_en,     // Parallel load commit
  input  wire logic [STAGES-1:0]       i_load_data,   // Parallel load value
  input  wire logic                    i_pattern_wr,  // Host write strobe for pattern
  input  wire logic [PATTERN_BITS-1:0] i_pattern,     // Host pattern value
  output logic                         o_burst_window,// Burst window
  output logic                         o_int_clk,     // Internal generated clock
  output logic      [STAGES-1:0]       o_rx_data,     // Stage outputs
  output logic      [PATTERN_BITS-1:0] o_pattern,     // Stored pattern readback
  output logic                         o_tx_enable,   // Transmit enable flip-flop
  output pin_drive_s                   o_data_pin,    // Data pin drive
  output pin_drive_s                   o_clk_pin      // Clock pin drive
);

  // Synchroniser stages; first stage feeds only the second
  logic [SYNC_W-1:0]       sync_meta;
  logic [SYNC_W-1:0]       sync;
  logic [SYNC_W-1:0]       sync_prev;   // For edge detection

  // Burst generator state
  logic                    window;      // Burst window
  logic                    osc;         // Oscillator level
  logic [DLY_W-1:0]        dly_cnt;     // Delay element count
  logic [CNT_W-1:0]        pulse_cnt;   // Pulses seen in this burst
  logic [CNT_W-1:0]        target;      // Pulse count latched at start

  // Line idle detector for internal rx
  logic [7:0]              idle_cnt;
  logic                    idle_fired;  // Blocks re-arming until line goes high

  // Shift register, load edge detect
  logic [STAGES-1:0]       stage;
  logic                    load_en_prev;

  // Transmit side
  logic                    tx_en;
  logic [PATTERN_BITS-1:0] pattern;
  logic [PATTERN_BITS-1:0] pat_sh;      // Working copy shifted out
  logic [CNT_W-1:0]        tx_cnt;      // Transmit clock pulses
  logic                    tx_done;     // Counter reached its end
  logic                    tx_done_prev;

  // Combinational helpers
  logic                    start_rise;
  logic                    idle_trig;
  logic                    trigger;
  logic                    dly_hit;
  logic                    osc_rise;
  logic                    osc_fall;
  logic                    shift_edge;
  logic                    load_commit;
  logic                    tx_stop;
  logic [DLY_W-1:0]        dly_last;
  logic [CNT_W-1:0]        next_target;

  // Pin synchroniser, two flops on every pin input
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_meta <= SYNC_RST;
      sync      <= SYNC_RST;
      sync_prev <= SYNC_RST;
    end else begin
      sync_meta <= {i_clk_pin, i_data_pin, i_ext_clk, i_clear_n, i_start};
      sync      <= sync_meta;
      sync_prev <= sync;
    end
  end

  // Trigger and edge decode
  always_comb begin
    start_rise  = sync[SY_START] & ~sync_prev[SY_START];
    idle_trig   = (i_mode == MODE_INT_RX) && !idle_fired && !sync[SY_DATA]
                  && (idle_cnt == IDLE_LOW_LAST);
    // A start while the window is open is dropped
    if (i_mode == MODE_INT_RX) begin
      trigger = idle_trig & ~window;
    end else begin
      trigger = start_rise & ~window;
    end
    // Zero delay would stall the oscillator, so treat it as one cycle
    dly_last    = (i_half_period == DLY_RST) ? DLY_RST : i_half_period - 8'h01;
    dly_hit     = window && (dly_cnt == dly_last);
    osc_rise    = dly_hit & ~osc;
    osc_fall    = dly_hit & osc;
    case (i_mode)
      MODE_INT_RX:   next_target = STAGE_COUNT;
      MODE_TX_FIRST: next_target = i_tx_count;
      default:       next_target = i_burst_count;
    endcase
  end

  // Idle-low detector: counts low cycles on the data line outside a burst
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt   <= 8'h00;
      idle_fired <= 1'b0;
    end else if (sync[SY_DATA] || i_mode != MODE_INT_RX) begin
      // Line high: rearm
      idle_cnt   <= 8'h00;
      idle_fired <= 1'b0;
    end else if (idle_trig) begin
      idle_fired <= 1'b1;
    end else if (!idle_fired && !window) begin
      idle_cnt   <= idle_cnt + 8'h01;
    end
  end

  // Window one-shot; its counter runs only on generated pulses
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      window    <= 1'b0;
      pulse_cnt <= CNT_RST;
      target    <= CNT_RST;
    end else if (trigger) begin
      window    <= 1'b1;
      pulse_cnt <= CNT_RST;
      target    <= next_target;
    end else if (osc_rise) begin
      pulse_cnt <= pulse_cnt + 5'h01;
    end else if (osc_fall && (pulse_cnt >= target)) begin
      // Close at the end of the last pulse's high half so every pulse is whole
      window    <= 1'b0;
    end
  end

  // Delay element: both-edge delay whose inverted output feeds back
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc     <= 1'b0;
      dly_cnt <= DLY_RST;
    end else if (!window || trigger) begin
      // Outside the window the loop is broken and restarts from low
      osc     <= 1'b0;
      dly_cnt <= DLY_RST;
    end else if (dly_hit) begin
      osc     <= ~osc;
      dly_cnt <= DLY_RST;
    end else begin
      dly_cnt <= dly_cnt + 8'h01;
    end
  end

  // Shift clock and load selection per mode
  always_comb begin
    case (i_mode)
      MODE_EXT_RX:   shift_edge = sync[SY_EXTCK] & ~sync_prev[SY_EXTCK];
      MODE_INT_RX:   shift_edge = osc_rise;
      // Partner clock is accepted only while the transmit enable is low
      MODE_TX_FIRST: shift_edge = sync[SY_PINCK] & ~sync_prev[SY_PINCK] & ~tx_en;
      default:       shift_edge = 1'b0;
    endcase
    load_commit = i_load_sel & i_load_en & ~load_en_prev;
  end

  // Load enable edge detect
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_en_prev <= 1'b0;
    end else begin
      load_en_prev <= i_load_en;
    end
  end

  // One flop per stage, each with a load selector ahead of it
  for (genvar g = 0; g < STAGES; g++) begin : g_stage
    logic serial_in;  // Bit arriving from the previous stage, or from the data pin at stage 0
    if (g == 0) begin : g_head
      assign serial_in = sync[SY_DATA];
    end else begin : g_body
      assign serial_in = stage[g-1];
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        stage[g] <= 1'b0;
      end else if (!sync[SY_CLR_N]) begin
        stage[g] <= 1'b0;
      end else if (load_commit) begin
        stage[g] <= i_load_data[g];
      end else if (shift_edge) begin
        stage[g] <= serial_in;
      end
    end
  end

  // Transmit done edge detector
  always_comb begin
    tx_stop = tx_done & ~tx_done_prev;
  end

  // Transmit enable flop; set first in every transaction
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_en        <= 1'b0;
      tx_cnt       <= CNT_RST;
      tx_done      <= 1'b0;
      tx_done_prev <= 1'b0;
    end else begin
      tx_done_prev <= tx_done;
      if (trigger && i_mode == MODE_TX_FIRST) begin
        tx_en   <= 1'b1;
        tx_cnt  <= CNT_RST;
        tx_done <= 1'b0;
      end else if (tx_stop) begin
        tx_en   <= 1'b0;
      end else if (tx_en && osc_rise) begin
        tx_cnt  <= tx_cnt + 5'h01;
      end else if (tx_en && osc_fall && (tx_cnt >= i_tx_count)) begin
        tx_done <= 1'b1;
      end else if (!tx_en) begin
        tx_done <= 1'b0;
      end
    end
  end

  // Pattern store; host writes are dropped mid-transmission
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pattern <= PATTERN_RST;
    end else if (i_pattern_wr && !tx_en) begin
      pattern <= i_pattern;
    end
  end

  // Serial emitter: next bit moves on the falling internal edge so the
  // partner samples a settled level on the rising one
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pat_sh <= PATTERN_RST;
    end else if (trigger && i_mode == MODE_TX_FIRST) begin
      pat_sh <= pattern;
    end else if (tx_en && osc_fall) begin
      pat_sh <= {pat_sh[PATTERN_BITS-2:0], 1'b0};
    end
  end

  // Pin drivers, registered; transmit enable gates clock and enables
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clk_pin  <= '0;
      o_data_pin <= '0;
    end else begin
      o_clk_pin.out  <= osc & tx_en;
      o_clk_pin.oe   <= tx_en;
      o_data_pin.out <= pat_sh[PATTERN_BITS-1] & tx_en;
      o_data_pin.oe  <= tx_en;
    end
  end

  // Status outputs, all straight from flops
  always_comb begin
    o_burst_window = window;
    o_int_clk      = osc;
    o_rx_data      = stage;
    o_pattern      = pattern;
    o_tx_enable    = tx_en;
  end

endmodule : preset_pulse_serial_shifter

// ==== dv/pps_props.sv ====
// Checker for the preset pulse serial shifter, bound onto its top ports.
// Assumes configuration inputs stay static while a burst or transmission runs.
`timescale 1ns/1ps
module pps_props
  import pps_pkg::*;
(
  input wire logic                    i_ref_clk,      // Reference clock
  input wire logic                    i_rst_n,        // Reset, active low
  input wire mode_e                   i_mode,         // Operating mode
  input wire logic [DLY_W-1:0]        i_half_period,  // Oscillator half period
  input wire logic [CNT_W-1:0]        i_burst_count,  // Pulses per burst
  input wire logic                    i_start,        // Start pin
  input wire logic                    i_clear_n,      // Clear pin, active low
  input wire logic                    i_load_sel,     // Load select
  input wire logic                    i_load_en,      // Load commit
  input wire logic [STAGES-1:0]       i_load_data,    // Load value
  input wire logic                    i_pattern_wr,   // Pattern write strobe
  input wire logic [PATTERN_BITS-1:0] i_pattern,      // Pattern value
  input wire logic                    o_burst_window, // Burst window
  input wire logic                    o_int_clk,      // Generated clock
  input wire logic [STAGES-1:0]       o_rx_data,      // Stage outputs
  input wire logic [PATTERN_BITS-1:0] o_pattern,      // Stored pattern
  input wire logic                    o_tx_enable,    // Transmit enable
  input wire pin_drive_s              o_data_pin,     // Data pin drive
  input wire pin_drive_s              o_clk_pin       // Clock pin drive
);
  logic [12:0] win_len;  // Cycles the window has stood high
  logic [7:0]  hh;       // Half period, zero read as one
  logic [4:0]  nn;       // Pulses expected in this burst
  assign hh = (i_half_period == 8'h00) ? 8'h01 : i_half_period;
  assign nn = (i_mode == MODE_INT_RX) ? STAGE_COUNT
              : ((i_burst_count == 5'h00) ? 5'h01 : i_burst_count);

  // Window length counter, cleared whenever the window is low
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_len <= 13'h0000;
    end else if (o_burst_window) begin
      win_len <= win_len + 13'h0001;
    end else begin
      win_len <= 13'h0000;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Start edges in the plain burst modes, and in transmit-first
  sequence burst_start;
    $rose(i_start) && !o_burst_window && (i_mode == MODE_EXT_RX || i_mode == MODE_IDLE);
  endsequence
  sequence tx_start;
    $rose(i_start) && !o_tx_enable && (i_mode == MODE_TX_FIRST);
  endsequence
  sequence window_done;
    $fell(o_burst_window) && (i_mode != MODE_TX_FIRST);
  endsequence
  // Load commit edge, only while the clear pin stands high
  sequence load_edge;
    $rose(i_load_en) && i_load_sel && i_clear_n;
  endsequence

  a_window_opens: assert property (burst_start |-> ##[2:5] o_burst_window)
    else $error("window did not open after start");
  a_window_length: assert property (window_done |-> win_len == 13'(2 * hh * nn))
    else $error("window length does not match pulse count");
  a_clk_gated: assert property ($rose(o_int_clk) |-> o_burst_window || o_tx_enable)
    else $error("generated clock rose outside a window");
  a_quiet_after: assert property (!o_burst_window && !o_tx_enable |-> !o_int_clk)
    else $error("generated clock high with no window");
  a_clear_all: assert property ($fell(i_clear_n) |-> ##[2:5]
      (o_rx_data == STAGE_RST))
    else $error("stages not cleared together");
  a_load_commit: assert property (load_edge |-> ##[1:2] (o_rx_data == i_load_data))
    else $error("parallel load not committed");
  a_pins_gated: assert property (o_clk_pin.oe == $past(o_tx_enable)
      && o_data_pin.oe == o_clk_pin.oe
      && o_clk_pin.out == ($past(o_int_clk) && $past(o_tx_enable)))
    else $error("pin drive not gated by transmit enable");
  a_pattern_write: assert property (i_pattern_wr && !o_tx_enable |=>
      o_pattern == $past(i_pattern))
    else $error("pattern write lost");
  a_pattern_locked: assert property (i_pattern_wr && o_tx_enable |=> $stable(o_pattern))
    else $error("pattern changed during transmission");
  a_tx_starts: assert property (tx_start |-> ##[2:5] o_tx_enable)
    else $error("transmit enable did not set");
endmodule : pps_props

bind preset_pulse_serial_shifter pps_props props_u (.i_ref_clk, .i_rst_n, .i_mode, .i_half_period,
  .i_burst_count, .i_start, .i_clear_n, .i_load_sel, .i_load_en, .i_load_data, .i_pattern_wr,
  .i_pattern, .o_burst_window, .o_int_clk, .o_rx_data, .o_pattern, .o_tx_enable, .o_data_pin,
  .o_clk_pin);

// ==== dv/pps_partner.sv ====
// Far-side IC model: clocks a word onto the shared lines and listens to the device.
// Assumes the bench resolves each line from the device's enables, with this side driving whenever the device does not and the bench does not hold data low.
`timescale 1ns/1ps
module pps_partner (
  input  wire logic        i_send,      // Rising edge sends i_word
  input  wire logic [3:0]  i_word,      // Word to send, msb first
  input  wire logic        i_dev_oe,    // Device drives the lines
  input  wire logic        i_line_clk,  // Resolved clock line
  input  wire logic        i_line_data, // Resolved data line
  output logic             o_clk,       // Clock this side drives
  output logic             o_data,      // Data this side drives
  output logic [15:0]      o_heard      // Bits heard from the device
);
  initial begin
    o_clk = 1'b0;
    o_data = 1'b1;
    o_heard = 16'h0000;
  end

  // Answer only once the device has let go; clock stands still between frames
  always @(posedge i_send) begin
    if (!i_dev_oe) begin
      for (int k = 3; k >= 0; k--) begin
        o_data = i_word[k];
        #200 o_clk = 1'b1;
        #200 o_clk = 1'b0;
      end
      o_data = ~o_data;  // Released line must not keep the last bit
    end
  end

  // Sample the device on its rising pin clock while it drives
  always @(posedge i_line_clk) begin
    if (i_dev_oe) begin
      o_heard <= {o_heard[14:0], i_line_data};
    end
  end
endmodule : pps_partner

// ==== dv/preset_pulse_serial_shifter_test.sv ====
// Self-checking bench for the preset pulse serial shifter and its far-side model.
// Assumes the checker is bound in by its own file; inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
  end \
end
module preset_pulse_serial_shifter_test import pps_pkg::*;;
  logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, clear_n = 1'b1;  // Pins
  logic        load_sel = 1'b0, load_en = 1'b0, pat_wr = 1'b0;          // Same domain
  logic        send = 1'b0, hold_low = 1'b0;  // Partner send, line held low
  mode_e       mode = MODE_IDLE;              // Operating mode
  logic [7:0]  half = 8'h02;                  // Half period
  logic [4:0]  bcount = 5'h03, tcount = 5'h10;
  logic [3:0]  load_data = 4'h0, word = 4'h0, rx;
  logic [15:0] pat = 16'h0000, pat_q, heard;
  logic        win, int_clk, tx_en, p_clk, p_data, clk_line, data_line;
  pin_drive_s  dpin, cpin;                    // Pin drives
  int          failures = 0, num_checks = 0, rises = 0;

  // Shared lines: whoever enables drives, otherwise the partner; hold_low forces the data line low
  assign clk_line = cpin.oe ? cpin.out : p_clk;
  assign data_line = dpin.oe ? dpin.out : (hold_low ? 1'b0 : p_data);

  preset_pulse_serial_shifter dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_mode(mode),
    .i_half_period(half), .i_burst_count(bcount), .i_tx_count(tcount), .i_start(start),
    .i_clear_n(clear_n), .i_ext_clk(p_clk), .i_data_pin(data_line), .i_clk_pin(clk_line),
    .i_load_sel(load_sel), .i_load_en(load_en), .i_load_data(load_data), .i_pattern_wr(pat_wr),
    .i_pattern(pat), .o_burst_window(win), .o_int_clk(int_clk), .o_rx_data(rx),
    .o_pattern(pat_q), .o_tx_enable(tx_en), .o_data_pin(dpin), .o_clk_pin(cpin));
  pps_partner partner_u (.i_send(send), .i_word(word), .i_dev_oe(dpin.oe), .i_line_clk(clk_line),
    .i_line_data(data_line), .o_clk(p_clk), .o_data(p_data), .o_heard(heard));

  // 20 MHz clock; count generated pulses
  always #25 clk = ~clk;
  always @(posedge int_clk) rises++;

  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles

  // Bounded wait on the window or the transmit enable
  task automatic wait_on(input bit use_tx, input logic lvl);
    int n = 0;
    while (((use_tx ? tx_en : win) !== lvl) && n < 4000) begin
      @(negedge clk);
      n++;
    end
    // Only a level still wrong after the whole bound counts as a hang
    if ((use_tx ? tx_en : win) !== lvl) begin
      failures++;
      wrap_up();
    end
  endtask : wait_on

  // Start pin held long enough for the synchroniser
  task automatic pulse_start;
    @(negedge clk) start = 1'b1;
    cycles(4);
    start = 1'b0;
  endtask : pulse_start

  task automatic do_load(input logic [3:0] v);
    @(negedge clk) load_data = v;
    load_sel = 1'b1;
    @(negedge clk) load_en = 1'b1;
    cycles(3);
    load_en = 1'b0;
    load_sel = 1'b0;
    `CHK("load", v, rx)
  endtask : do_load

  // Counts 0, 1 and 3 with a start repeated inside each window
  task automatic t_burst;
    logic [4:0] cnt [3] = '{5'h00, 5'h01, 5'h03};
    int         exp_p [3] = '{1, 1, 3};
    half = 8'h06;  // Long enough that the repeated start lands in the window
    for (int k = 0; k < 3; k++) begin
      bcount = cnt[k];
      rises = 0;
      pulse_start();
      wait_on(0, 1'b1);
      pulse_start();
      wait_on(0, 1'b0);
      cycles(20);
      `CHK("burst pulses", exp_p[k], rises)
    end
    $display("t_burst done");
  endtask : t_burst

  task automatic t_load_clear;
    mode = MODE_EXT_RX;
    do_load(4'h5);
    clear_n = 1'b0;
    cycles(6);
    `CHK("clear", STAGE_RST, rx)
    clear_n = 1'b1;
    $display("t_load_clear done");
  endtask : t_load_clear

  task automatic t_ext_rx;
    word = 4'ha;
    send = 1'b1;
    cycles(40);
    send = 1'b0;
    `CHK("ext rx", 4'ha, rx)
    $display("t_ext_rx done");
  endtask : t_ext_rx

  task automatic t_int_rx;
    half = 8'h02;
    do_load(4'hf);
    mode = MODE_INT_RX;
    rises = 0;
    hold_low = 1'b1;
    wait_on(0, 1'b1);
    wait_on(0, 1'b0);
    hold_low = 1'b0;
    `CHK("int rx", 4'h0, rx)
    `CHK("int pulses", 4, rises)
    $display("t_int_rx done");
  endtask : t_int_rx

  task automatic t_tx_first;
    mode = MODE_TX_FIRST;
    half = 8'h04;
    @(negedge clk) pat = 16'h9c5a;
    pat_wr = 1'b1;
    @(negedge clk) pat_wr = 1'b0;
    `CHK("pattern", 16'h9c5a, pat_q)
    pat = 16'h0000;
    pulse_start();
    wait_on(1, 1'b1);
    pat_wr = 1'b1;
    @(negedge clk) pat_wr = 1'b0;
    wait_on(1, 1'b0);
    cycles(3);
    `CHK("pattern kept", 16'h9c5a, pat_q)
    `CHK("heard", 16'h9c5a, heard)
    `CHK("pins released", 1'b0, dpin.oe)
    word = 4'h6;
    send = 1'b1;
    cycles(40);
    send = 1'b0;
    `CHK("answer", 4'h6, rx)
    $display("t_tx_first done");
  endtask : t_tx_first

  initial begin
    cycles(3);
    rst_n = 1'b1;
    cycles(2);
    `CHK("pattern reset", PATTERN_RST, pat_q)
    t_burst();
    t_load_clear();
    t_ext_rx();
    t_int_rx();
    t_tx_first();
    wrap_up();
  end
endmodule : preset_pulse_serial_shifter_test
